// ===== scp_framer.sv
// Serial channel packet body framer: channel word, block headers, packed bytes
//
// Behaviour
// - Bytes of many subchannels travel in one packet, each in its own block.
// - The body opens with a 32-bit channel word before any block.
// - Channel word bit 31 tells whether blocks carry time tags.
// - Channel word bits 30..0 are sent as zero.
// - Each block has a header: optional time tag, then identity word.
// - Header is 4 bytes without time tag, 12 bytes with it.
// - Header order: time low long word, time high long word, identity word.
// - Relative time is the 48-bit count at the first byte; top 16 zero.
// - Absolute time replaces it when the packet flags select absolute time.
// - The identity word is always sent, whatever the time tag setting.
// - Identity bit 31 flags a parity fault in the block; bit 30 zero.
// - Identity bits 29..16 hold the subchannel number of the block.
// - Subchannel zero is the first or only subchannel.
// - Identity bits 15..0 hold the byte count of the block.
// - Two bytes per word, earlier byte low, filler high when count odd.
// - Long fields go out as 16-bit words, low half first.
`timescale 1ns/10ps
module scp_framer
    import scp_pkg::*;
#(
    parameter int unsigned MAX_BYTES = 65535
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              start_pkt,
    input  wire logic              end_pkt,
    input  wire logic              ts_enable,
    input  wire logic              abs_time_sel,
    input  wire logic              in_valid,
    input  scp_byte_t              in_byte,
    output logic                   in_ready,
    output logic [WORD_W-1:0]      out_word,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic                   pkt_done
);

    // -------------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------------
    localparam int unsigned AW = 16;
    localparam logic [LEN_W-1:0] CNT_MAX = LEN_W'(MAX_BYTES);

    initial begin
        if (MAX_BYTES < 1 || MAX_BYTES > 65535) begin
            $error("MAX_BYTES must lie in 1..65535");
        end
    end

    // -------------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_n_reg;

    // Async assert, two-stage release
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // -------------------------------------------------------------------------
    // State and working registers
    // -------------------------------------------------------------------------
    scp_state_t        state_reg;
    logic [2:0]        idx_reg;
    logic [LEN_W-1:0]  cnt_reg;
    logic [SUB_W-1:0]  sub_reg;
    logic              perr_reg;
    logic [TIME_W-1:0] time_reg;
    logic [AW-2:0]     rd_reg;
    scp_byte_t         pend_reg;
    logic              pend_valid_reg;
    logic              end_req_reg;
    logic              ts_en_reg;
    logic              abs_mode_reg;
    logic              out_valid_reg;
    logic [WORD_W-1:0] out_word_reg;
    logic              in_ready_reg;
    logic              pkt_done_reg;

    logic              can_load;
    logic              take;
    logic              new_sub;
    logic              wr_en;
    scp_byte_t         wr_byte;
    logic [LEN_W-1:0]  cnt_after;
    logic              close_blk;
    logic              finish_empty;
    logic [AW-2:0]     rd_last;
    logic              data_last;
    logic [WORD_W-1:0] store_word;
    scp_chan_word_t    chan_word;
    scp_id_word_t      id_word;
    logic [95:0]       hdr_bits;

    assign in_ready  = in_ready_reg;
    assign out_word  = out_word_reg;
    assign out_valid = out_valid_reg;
    assign pkt_done  = pkt_done_reg;

    // -------------------------------------------------------------------------
    // Collect decisions
    // -------------------------------------------------------------------------
    // Output slot free when empty or being drained this cycle
    assign can_load  = !out_valid_reg || out_ready;
    assign take      = in_valid && in_ready_reg;
    // A foreign subchannel byte is parked, not mixed into the block
    assign new_sub   = take && (cnt_reg != LEN_ZERO) && (in_byte.sub != sub_reg);
    // A parked byte opens the next block before new input is taken
    assign wr_en     = (state_reg == ST_COLLECT) && (pend_valid_reg || (take && !new_sub));
    assign wr_byte   = pend_valid_reg ? pend_reg : in_byte;
    assign cnt_after = cnt_reg + LEN_W'(wr_en);
    assign close_blk = (state_reg == ST_COLLECT) && (new_sub || cnt_after == CNT_MAX
                       || (end_req_reg && cnt_after != LEN_ZERO));
    assign finish_empty = (state_reg == ST_COLLECT) && end_req_reg && (cnt_after == LEN_ZERO);

    // Data words: last index is (count - 1) / 2
    assign rd_last   = (AW-1)'((cnt_reg - 16'h0001) >> 1);
    assign data_last = (rd_reg == rd_last);

    // -------------------------------------------------------------------------
    // Word images
    // -------------------------------------------------------------------------
    assign chan_word = '{ts_en: ts_en_reg, rsv: RSV_CHAN};
    assign id_word   = '{parity_fault_flag: perr_reg, rsv: 1'b0,
                         sub: sub_reg, len: cnt_reg};
    // Time low long word, time high long word, identity word, low halves first
    assign hdr_bits  = {id_word, time_reg};

    scp_byte_store #(
        .AW      (AW)
    ) u_store (
        .ref_clk (ref_clk),
        .wr_en   (wr_en),
        .wr_addr (cnt_reg),
        .wr_data (wr_byte.data),
        .rd_word (rd_reg),
        .rd_data (store_word)
    );

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
            idx_reg   <= HDR_TS_IDX;
            rd_reg    <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_pkt) begin
                        state_reg <= ST_CHAN;
                        idx_reg   <= HDR_TS_IDX;
                    end
                end
                ST_CHAN: begin
                    if (can_load) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == CHAN_LAST) begin
                            state_reg <= ST_COLLECT;
                        end
                    end
                end
                ST_COLLECT: begin
                    if (close_blk) begin
                        state_reg <= ST_HEAD;
                        idx_reg   <= ts_en_reg ? HDR_TS_IDX : HDR_ID_IDX;
                    end else if (finish_empty) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HEAD: begin
                    if (can_load) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == HDR_LAST) begin
                            state_reg <= ST_DATA;
                            rd_reg    <= '0;
                        end
                    end
                end
                ST_DATA: begin
                    if (can_load) begin
                        rd_reg <= rd_reg + 1'b1;
                        if (data_last) begin
                            // A parked byte still owes its own block before the packet may end
                            state_reg <= (end_req_reg && !pend_valid_reg) ? ST_IDLE : ST_COLLECT;
                        end
                    end
                end
            endcase
        end
    end

    // Packet-wide settings latched when a packet opens
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ts_en_reg    <= 1'b0;
            abs_mode_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && start_pkt) begin
            ts_en_reg    <= ts_enable;
            abs_mode_reg <= abs_time_sel;
        end
    end

    // End request: set wins over the clear at packet finish
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            end_req_reg <= 1'b0;
        end else if (end_pkt && state_reg != ST_IDLE) begin
            end_req_reg <= 1'b1;
        end else if (state_reg == ST_IDLE || finish_empty) begin
            end_req_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Block bookkeeping
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cnt_reg  <= LEN_ZERO;
            sub_reg  <= '0;
            perr_reg <= 1'b0;
            time_reg <= '0;
        end else begin
            if (wr_en) begin
                cnt_reg <= cnt_after;
                if (cnt_reg == LEN_ZERO) begin
                    // First byte fixes subchannel and time of the block
                    sub_reg  <= wr_byte.sub;
                    perr_reg <= wr_byte.parity_err;
                    time_reg <= abs_mode_reg ? wr_byte.abs_time
                                             : {REL_PAD, wr_byte.rel_time};
                end else begin
                    perr_reg <= perr_reg | wr_byte.parity_err;
                end
            end else if (state_reg == ST_DATA && can_load && data_last) begin
                cnt_reg <= LEN_ZERO;
            end
        end
    end

    // Parked byte of a different subchannel
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pend_valid_reg <= 1'b0;
            pend_reg       <= '0;
        end else if (new_sub) begin
            pend_valid_reg <= 1'b1;
            pend_reg       <= in_byte;
        end else if (wr_en) begin
            pend_valid_reg <= 1'b0;
        end
    end

    // Input ready only while collecting with room and nothing parked
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            in_ready_reg <= 1'b0;
        end else begin
            in_ready_reg <= (state_reg == ST_COLLECT) && !close_blk && !finish_empty
                            && !new_sub && !(end_pkt || end_req_reg) && cnt_after != CNT_MAX;
        end
    end

    // -------------------------------------------------------------------------
    // Output word register
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            out_valid_reg <= 1'b0;
            out_word_reg  <= '0;
        end else if (can_load && state_reg == ST_CHAN) begin
            out_valid_reg <= 1'b1;
            out_word_reg  <= (idx_reg == HDR_TS_IDX) ? chan_word[15:0] : chan_word[31:16];
        end else if (can_load && state_reg == ST_HEAD) begin
            out_valid_reg <= 1'b1;
            out_word_reg  <= hdr_bits[32'(idx_reg) * WORD_W +: WORD_W];
        end else if (can_load && state_reg == ST_DATA) begin
            out_valid_reg <= 1'b1;
            // Odd count: upper half of the last word is filler
            out_word_reg  <= (data_last && cnt_reg[0]) ? {FILL_BYTE, store_word[7:0]} : store_word;
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    // Packet finished, pulsed as the last word is loaded, or when the end request finds no bytes collected
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pkt_done_reg <= 1'b0;
        end else begin
            pkt_done_reg <= finish_empty
                            || (state_reg == ST_DATA && can_load && data_last && end_req_reg && !pend_valid_reg);
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    sequence s_head_start;
        state_reg == ST_HEAD && can_load;
    endsequence

    a_chan_low_word: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        state_reg == ST_CHAN && can_load && idx_reg == HDR_TS_IDX |=> out_valid && out_word == 16'h0000)
        else $error("channel word low half not zero");

    a_chan_high_word: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        state_reg == ST_CHAN && can_load && idx_reg == CHAN_LAST |=> out_word == {ts_en_reg, 15'h0000})
        else $error("channel word high half wrong");

    a_head_length: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        close_blk && ts_en_reg |=> (state_reg == ST_HEAD && idx_reg == HDR_TS_IDX))
        else $error("timed header does not start at time low word");

    a_ident_always: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        close_blk && !ts_en_reg |=> (state_reg == ST_HEAD && idx_reg == HDR_ID_IDX))
        else $error("identity word not next");

    a_time_high_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        s_head_start and (idx_reg == HDR_TH_IDX && !abs_mode_reg) |=> out_word == 16'h0000)
        else $error("relative time top bits not zero");

    a_ident_count: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        s_head_start and (idx_reg == HDR_ID_IDX) |=> out_word == $past(cnt_reg))
        else $error("identity count wrong");

    a_ident_upper: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        s_head_start and (idx_reg == HDR_LAST) |=> out_word == {$past(perr_reg), 1'b0, $past(sub_reg)})
        else $error("identity upper half wrong");

    a_odd_filler: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        state_reg == ST_DATA && can_load && data_last && cnt_reg[0] |=> out_word[15:8] == FILL_BYTE)
        else $error("filler byte missing");

    a_sub_change: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        new_sub |=> state_reg == ST_HEAD ##0 pend_valid_reg)
        else $error("subchannel change did not close block");

    a_count_cap: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        cnt_reg <= CNT_MAX)
        else $error("byte count above limit");

    a_out_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("output word changed while stalled");

endmodule // scp_framer

// ===== scp_pkg.sv
// Shared types and constants of the serial channel packetizer
package scp_pkg;

    // -------------------------------------------------------------------------
    // Field layouts
    // -------------------------------------------------------------------------
    localparam int unsigned SUB_W    = 14;
    localparam int unsigned LEN_W    = 16;
    localparam int unsigned REL_W    = 48;
    localparam int unsigned TIME_W   = 64;
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned BYTE_W   = 8;

    // Channel word: time tag enable on top, rest reserved
    typedef struct packed {
        logic        ts_en;
        logic [30:0] rsv;
    } scp_chan_word_t;

    // Block identity word
    typedef struct packed {
        logic             parity_fault_flag;
        logic             rsv;
        logic [SUB_W-1:0] sub;
        logic [LEN_W-1:0] len;
    } scp_id_word_t;

    // One received serial byte with its capture times
    typedef struct packed {
        logic              parity_err;
        logic [SUB_W-1:0]  sub;
        logic [REL_W-1:0]  rel_time;
        logic [TIME_W-1:0] abs_time;
        logic [BYTE_W-1:0] data;
    } scp_byte_t;

    // -------------------------------------------------------------------------
    // Constants
    // -------------------------------------------------------------------------
    localparam logic [30:0]       RSV_CHAN   = 31'h0000_0000;
    localparam logic [15:0]       REL_PAD    = 16'h0000;
    localparam logic [BYTE_W-1:0] FILL_BYTE  = 8'h00;
    localparam logic [LEN_W-1:0]  LEN_MAX    = 16'hffff;
    localparam logic [LEN_W-1:0]  LEN_ZERO   = 16'h0000;
    localparam logic [2:0]        HDR_TS_IDX = 3'h0;
    localparam logic [2:0]        HDR_TH_IDX = 3'h3;
    localparam logic [2:0]        HDR_ID_IDX = 3'h4;
    localparam logic [2:0]        HDR_LAST   = 3'h5;
    localparam logic [2:0]        CHAN_LAST  = 3'h1;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_CHAN    = 5'b00010,
        ST_COLLECT = 5'b00100,
        ST_HEAD    = 5'b01000,
        ST_DATA    = 5'b10000
    } scp_state_t;

endpackage

// ===== scp_byte_store.sv
// Byte store holding one block while its header is emitted
`timescale 1ns/10ps
module scp_byte_store
    import scp_pkg::*;
#(
    parameter int unsigned AW = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              wr_en,
    input  wire logic [AW-1:0]     wr_addr,
    input  wire logic [BYTE_W-1:0] wr_data,
    input  wire logic [AW-2:0]     rd_word,
    output logic      [WORD_W-1:0] rd_data
);

    // -------------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------------
    logic [BYTE_W-1:0] mem [0:(2**AW)-1];

    // Write one byte per cycle; no reset, contents are rewritten per block
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Earlier byte lands in the low half
    assign rd_data = {mem[{rd_word, 1'b1}], mem[{rd_word, 1'b0}]};

endmodule // scp_byte_store

// ===== scp_recorder.sv
// Recorder-side model: takes framed words with a steady or throttled ready
`timescale 1ns/10ps
module scp_recorder
    import scp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              stall,
    input  wire logic [WORD_W-1:0] out_word,
    input  wire logic              out_valid,
    output logic                   out_ready
);
    logic [WORD_W-1:0] words[$];
    logic [1:0]        phase_reg;

    // Free-running phase; slow mode takes one word in four so held words are seen
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign out_ready = !stall || (phase_reg == 2'h3);

    // Store every word that leaves on a handshake
    always @(posedge ref_clk) begin
        if (out_valid && out_ready) begin
            words.push_back(out_word);
        end
    end
endmodule // scp_recorder

// ===== serial_channel_packetizer_tb.sv
// Self-checking bench of the serial channel packet body framer
`timescale 1ns/10ps
module serial_channel_packetizer_tb
    import scp_pkg::*;
;
    localparam int MAXB = 4;  // Small block limit keeps the full-count split cheap
    logic ref_clk = 1'b0, nrst = 1'b0, start_pkt = 1'b0, end_pkt = 1'b0;
    logic ts_enable = 1'b0, abs_time_sel = 1'b0, in_valid = 1'b0, stall = 1'b0;
    scp_byte_t in_byte = '0;
    logic in_ready, out_valid, out_ready, pkt_done;
    logic [WORD_W-1:0] out_word;
    logic [WORD_W-1:0] exp[$];
    scp_byte_t bq[$];
    int failures = 0, n_tests = 0, done_cnt = 0;

    always #5 ref_clk = ~ref_clk;

    scp_framer #(.MAX_BYTES(MAXB)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .start_pkt(start_pkt),
        .end_pkt(end_pkt), .ts_enable(ts_enable), .abs_time_sel(abs_time_sel), .in_valid(in_valid),
        .in_byte(in_byte), .in_ready(in_ready), .out_word(out_word), .out_valid(out_valid),
        .out_ready(out_ready), .pkt_done(pkt_done));
    scp_recorder u_rec (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .out_word(out_word),
        .out_valid(out_valid), .out_ready(out_ready));

    always @(posedge ref_clk) if (pkt_done === 1'b1) done_cnt++;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] expv, input string msg);
        n_tests++;
        if (got !== expv) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, expv);
        end
    endtask

    // Distinct halves in each time so a swapped word order shows up
    function automatic scp_byte_t mk(input logic pe, input logic [13:0] sub, input logic [7:0] d);
        return {pe, sub, {40'h12_3456_789a, d}, {56'h9abc_def0_1357_24, d}, d};
    endfunction

    task automatic add32(input logic [31:0] v);
        exp.push_back(v[15:0]);
        exp.push_back(v[31:16]);
    endtask

    // Expected body worked out from the field layout
    task automatic build(input logic ts, input logic ab);
        int i, j;
        logic pe;
        logic [63:0] t;
        exp = {};
        add32({ts, 31'h0});
        i = 0;
        while (i < bq.size()) begin
            j = i;
            pe = 1'b0;
            while (j < bq.size() && bq[j].sub == bq[i].sub && j - i < MAXB) begin
                pe |= bq[j].parity_err;
                j++;
            end
            t = ab ? bq[i].abs_time : {16'h0000, bq[i].rel_time};
            if (ts) begin
                add32(t[31:0]);
                add32(t[63:32]);
            end
            add32({pe, 1'b0, bq[i].sub, 16'(j - i)});
            for (int k = i; k < j; k += 2) exp.push_back({(k + 1 < j) ? bq[k + 1].data : 8'h00, bq[k].data});
            i = j;
        end
    endtask

    // One packet: open, offer bytes under handshake, close, compare body
    task automatic run_pkt(input logic ts, input logic ab, input logic slow, input string name);
        int w;
        build(ts, ab);
        u_rec.words = {};
        done_cnt = 0;
        stall <= slow;
        ts_enable <= ts;
        abs_time_sel <= ab;
        start_pkt <= 1'b1;
        @(posedge ref_clk);
        start_pkt <= 1'b0;
        foreach (bq[n]) begin
            in_valid <= 1'b1;
            in_byte <= bq[n];
            w = 0;
            do begin
                @(posedge ref_clk);
                w++;
            end while (in_ready !== 1'b1 && w < 300);
            check(w < 300, 1, "byte not taken");
        end
        in_valid <= 1'b0;
        end_pkt <= 1'b1;
        @(posedge ref_clk);
        end_pkt <= 1'b0;
        w = 0;
        while (u_rec.words.size() < exp.size() && w < 600) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (8) @(posedge ref_clk);
        check(u_rec.words.size(), exp.size(), "word count");
        foreach (exp[n]) if (n < u_rec.words.size()) check(u_rec.words[n], exp[n], "body word");
        check(done_cnt, 1, "done pulses");
        $display("test %s finished", name);
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic s_plain;  // Odd block without time tags, one byte flags parity
        bq = '{mk(1'b0, 14'h2, 8'h11), mk(1'b1, 14'h2, 8'h22), mk(1'b0, 14'h2, 8'h33)};
        run_pkt(1'b0, 1'b0, 1'b0, "plain");
    endtask

    task automatic s_rel_switch;  // Relative tags, subchannel change mid-stream, slow recorder
        bq = '{mk(1'b0, 14'h0, 8'h41), mk(1'b0, 14'h0, 8'h42), mk(1'b0, 14'h3fff, 8'h43)};
        run_pkt(1'b1, 1'b0, 1'b1, "rel_switch");
    endtask

    task automatic s_abs_full;  // Absolute tags, block splits when its count is full
        bq = '{mk(1'b0, 14'h1, 8'h51), mk(1'b0, 14'h1, 8'h52), mk(1'b0, 14'h1, 8'h53),
               mk(1'b0, 14'h1, 8'h54), mk(1'b1, 14'h1, 8'h55)};
        run_pkt(1'b1, 1'b1, 1'b0, "abs_full");
    endtask

    task automatic s_empty;  // No bytes: only the channel word leaves
        bq = {};
        run_pkt(1'b1, 1'b0, 1'b0, "empty");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog sized well beyond the four packets
    initial begin
        #200000;
        failures++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        s_plain();
        s_rel_switch();
        s_abs_full();
        s_empty();
        final_report();
    end
endmodule // serial_channel_packetizer_tb
